// File: logic/wdg_if.sv
// carriers between the register file and its timer and pin slices
`timescale 1ns/1ps
interface wdg_tmr_if;
   logic load;
   logic [7:0] load_value;
   logic unit_sec;
   logic run;
   logic expire;
   logic [7:0] remain;
   modport ctl (output load, output load_value, output unit_sec, output run,
      input expire, input remain);
   modport tmr (input load, input load_value, input unit_sec, input run,
      output expire, output remain);
endinterface

interface wdg_pin_if;
   logic [7:0][7:0] cfg;
   logic [7:0] data;
   logic [7:0] level_in;
   modport ctl (output cfg, output data, input level_in);
   modport pin (input cfg, input data, output level_in);
endinterface

// File: logic/wdg_map.svh
// register offsets, field positions, reset values and timing figures of the watchdog/gpio block
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH
// ==================================================================
// runtime register offsets
`define WDG_OFS_PIN0_CFG 8'h23
`define WDG_OFS_PIN1_CFG 8'h24
`define WDG_OFS_PIN2_CFG 8'h25
`define WDG_OFS_PIN3_CFG 8'h26
`define WDG_OFS_PIN4_CFG 8'h27
`define WDG_OFS_PIN5_CFG 8'h29
`define WDG_OFS_PIN6_CFG 8'h2A
`define WDG_OFS_PIN7_CFG 8'h2B
`define WDG_OFS_ENABLE 8'h47
`define WDG_OFS_LEVELS 8'h4B
`define WDG_OFS_UNITS 8'h65
`define WDG_OFS_COUNT 8'h66
`define WDG_OFS_STATUS 8'h68
// ==================================================================
// field positions and values
`define WDG_ENABLE_KEY 8'h0C
`define WDG_UNIT_BIT 7
`define WDG_STATUS_BIT 0
`define WDG_CFG_DIR_BIT 0
`define WDG_CFG_INV_BIT 1
`define WDG_CFG_OD_BIT 7
`define WDG_COUNT_OFF 8'h00
// ==================================================================
// reset values
`define WDG_RST_PIN_CFG 8'h01
`define WDG_RST_BYTE 8'h00
// ==================================================================
// timing
`define WDG_CLK_MHZ 250
`define WDG_HZ_PER_MHZ 1000000
`define WDG_TICK_S 1
`define WDG_SECS_PER_MIN 60
`endif

// File: logic/wdg_pins.sv
// eight general purpose pin slices: direction, polarity and driver type
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_pins import wdg_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   wdg_pin_if.pin pif
);
   wdg_pin_state_t s_reg, s_next;
   logic [7:0] level;

   always_comb begin
      s_next = s_reg;
      for (int n = 0; n < 8; n++) begin
         level[n] = pif.data[n] ^ pif.cfg[n][`WDG_CFG_INV_BIT];
         if (pif.cfg[n][`WDG_CFG_OD_BIT]) begin
            // open drain only ever pulls low; high is left to the pull-up
            s_next.pin_out[n] = 1'b0;
            s_next.pin_oe[n] = !pif.cfg[n][`WDG_CFG_DIR_BIT] && !level[n];
         end else begin
            s_next.pin_out[n] = level[n];
            s_next.pin_oe[n] = !pif.cfg[n][`WDG_CFG_DIR_BIT];
         end
         pif.level_in[n] = pin_in[n] ^ pif.cfg[n][`WDG_CFG_INV_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '{pin_out: `WDG_RST_BYTE, pin_oe: `WDG_RST_BYTE};
      end else begin
         s_reg <= s_next;
      end
   end

   assign pin_out = s_reg.pin_out;
   assign pin_oe = s_reg.pin_oe;
endmodule

// File: logic/wdg_pkg.sv
// types shared by the watchdog/gpio modules
package wdg_pkg;
   // ==================================================================
   // watchdog countdown states, gray along idle -> count -> expired
   typedef enum logic [1:0] {
      WT_IDLE = 2'h0,
      WT_COUNT = 2'h1,
      WT_EXPIRED = 2'h3
   } wdg_tmr_fsm_t;

   typedef struct packed {
      wdg_tmr_fsm_t fsm;
      logic [31:0] presc;
      logic [7:0] mins;
      logic [7:0] remain;
      logic expire;
   } wdg_tmr_state_t;

   typedef struct packed {
      logic [7:0] pin_out;
      logic [7:0] pin_oe;
   } wdg_pin_state_t;

   typedef struct packed {
      logic [7:0][7:0] pin_cfg;
      logic [7:0] pin_data;
      logic [7:0] wd_enable;
      logic wd_unit_sec;
      logic [7:0] wd_count;
      logic wd_status;
      logic wd_load;
      logic [7:0] rdata;
   } wdg_regs_t;
endpackage

// File: logic/wdg_timer.sv
// watchdog countdown with seconds and minutes prescaler
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_timer import wdg_pkg::*; #(
   parameter int CYC_PER_SEC = `WDG_TICK_S * `WDG_CLK_MHZ * `WDG_HZ_PER_MHZ,
   parameter int SECS_PER_MIN = `WDG_SECS_PER_MIN
) (
   input wire logic clk,
   input wire logic reset,
   wdg_tmr_if.tmr tif
);
   if (CYC_PER_SEC < 1 || SECS_PER_MIN < 1 || SECS_PER_MIN > 256) begin : g_chk
      $error("wdg_timer: tick parameters out of range");
   end

   wdg_tmr_state_t s_reg, s_next;
   logic sec_tick, min_tick, unit_tick;

   always_comb begin
      s_next = s_reg;
      s_next.expire = 1'b0;
      sec_tick = s_reg.presc == 32'(CYC_PER_SEC - 1);
      min_tick = sec_tick && s_reg.mins == 8'(SECS_PER_MIN - 1);
      unit_tick = tif.unit_sec ? sec_tick : min_tick;
      if (tif.load || !tif.run || s_reg.fsm == WT_IDLE) begin
         // a rewrite restarts the whole period, prescaler included
         s_next.presc = '0;
         s_next.mins = '0;
         s_next.remain = tif.load_value;
         s_next.fsm = tif.run ? WT_COUNT : WT_IDLE;
      end else begin
         unique case (s_reg.fsm)
            WT_COUNT: begin
               s_next.presc = sec_tick ? '0 : s_reg.presc + 32'h1;
               if (sec_tick) begin
                  s_next.mins = min_tick ? '0 : s_reg.mins + 8'h1;
               end
               if (unit_tick) begin
                  s_next.remain = s_reg.remain - 8'h1;
                  if (s_reg.remain == 8'h01) begin
                     s_next.expire = 1'b1;
                     s_next.fsm = WT_EXPIRED;
                  end
               end
            end
            WT_EXPIRED: s_next = s_reg;
            default: s_next.fsm = WT_IDLE;
         endcase
         if (s_reg.fsm == WT_EXPIRED) begin
            s_next.expire = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '{fsm: WT_IDLE, presc: '0, mins: '0, remain: '0, expire: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign tif.expire = s_reg.expire;
   assign tif.remain = s_reg.remain;
endmodule

// File: logic/wdg_top.sv
// watchdog and gpio runtime register block with byte-wide i/o port
// ==================================================================
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_top import wdg_pkg::*; #(
   parameter int CYC_PER_SEC = `WDG_TICK_S * `WDG_CLK_MHZ * `WDG_HZ_PER_MHZ,
   parameter int SECS_PER_MIN = `WDG_SECS_PER_MIN
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic wd_timeout
);
   // ==================================================================
   // elaboration checks
   if (CYC_PER_SEC < 1) begin : g_chk_sec
      $error("wdg_top: CYC_PER_SEC must be at least one");
   end
   if (SECS_PER_MIN < 1 || SECS_PER_MIN > 256) begin : g_chk_min
      $error("wdg_top: SECS_PER_MIN must lie in 1..256");
   end

   // ==================================================================
   // address decoding
   // the config offsets skip one address, so a plain subtract would
   // misplace pins five to seven; the table keeps the gap explicit
   function automatic logic [3:0] cfg_slot(input logic [7:0] a);
      logic [3:0] r;
      r = 4'h0;
      unique case (a)
         `WDG_OFS_PIN0_CFG: r = 4'h8;
         `WDG_OFS_PIN1_CFG: r = 4'h9;
         `WDG_OFS_PIN2_CFG: r = 4'hA;
         `WDG_OFS_PIN3_CFG: r = 4'hB;
         `WDG_OFS_PIN4_CFG: r = 4'hC;
         `WDG_OFS_PIN5_CFG: r = 4'hD;
         `WDG_OFS_PIN6_CFG: r = 4'hE;
         `WDG_OFS_PIN7_CFG: r = 4'hF;
         default: r = 4'h0;
      endcase
      return r;
   endfunction

   // ==================================================================
   // state
   wdg_regs_t s_reg, s_next;
   logic [3:0] slot;
   logic wd_armed;
   logic [7:0] level_rd;

   wdg_tmr_if tif();
   wdg_pin_if pif();

   // ==================================================================
   // watchdog slice
   wdg_timer #(
      .CYC_PER_SEC(CYC_PER_SEC),
      .SECS_PER_MIN(SECS_PER_MIN)
   ) u_timer (
      .clk(clk),
      .reset(reset),
      .tif(tif)
   );

   // the timer only runs on the enable key and a nonzero count
   assign wd_armed = s_reg.wd_enable == `WDG_ENABLE_KEY
      && s_reg.wd_count != `WDG_COUNT_OFF;
   assign tif.load = s_reg.wd_load;
   assign tif.load_value = s_reg.wd_count;
   assign tif.unit_sec = s_reg.wd_unit_sec;
   assign tif.run = wd_armed;

   // ==================================================================
   // pin slice
   wdg_pins u_pins (
      .clk(clk),
      .reset(reset),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .pif(pif)
   );

   assign pif.cfg = s_reg.pin_cfg;
   assign pif.data = s_reg.pin_data;

   // ==================================================================
   // register file
   always_comb begin
      s_next = s_reg;
      s_next.wd_load = 1'b0;
      slot = cfg_slot(bus_addr);

      // pins set as input read their live level, outputs read the latch
      for (int n = 0; n < 8; n++) begin
         level_rd[n] = s_reg.pin_cfg[n][`WDG_CFG_DIR_BIT] ?
            pif.level_in[n] : s_reg.pin_data[n];
      end

      // writes
      if (bus_wr) begin
         if (slot[3]) begin
            s_next.pin_cfg[slot[2:0]] = bus_wdata;
         end
         unique case (bus_addr)
            `WDG_OFS_LEVELS: s_next.pin_data = bus_wdata;
            `WDG_OFS_ENABLE: s_next.wd_enable = bus_wdata;
            `WDG_OFS_UNITS: s_next.wd_unit_sec = bus_wdata[`WDG_UNIT_BIT];
            `WDG_OFS_COUNT: begin
               s_next.wd_count = bus_wdata;
               s_next.wd_load = 1'b1;
            end
            `WDG_OFS_STATUS: s_next.wd_status = bus_wdata[`WDG_STATUS_BIT];
            default: s_next.wd_load = 1'b0;
         endcase
      end

      // a timeout in the same cycle as a software clear still lands
      if (tif.expire) begin
         s_next.wd_status = 1'b1;
      end

      // reads, answered one cycle after the strobe
      if (bus_rd) begin
         s_next.rdata = `WDG_RST_BYTE;
         if (slot[3]) begin
            s_next.rdata = s_reg.pin_cfg[slot[2:0]];
         end
         unique case (bus_addr)
            `WDG_OFS_LEVELS: s_next.rdata = level_rd;
            `WDG_OFS_ENABLE: s_next.rdata = s_reg.wd_enable;
            `WDG_OFS_UNITS: s_next.rdata[`WDG_UNIT_BIT] = s_reg.wd_unit_sec;
            `WDG_OFS_COUNT: s_next.rdata = s_reg.wd_count;
            `WDG_OFS_STATUS: s_next.rdata[`WDG_STATUS_BIT] = s_reg.wd_status;
            default: s_next.rdata = s_next.rdata;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg.pin_cfg <= {8{`WDG_RST_PIN_CFG}};
         s_reg.pin_data <= `WDG_RST_BYTE;
         s_reg.wd_enable <= `WDG_RST_BYTE;
         s_reg.wd_unit_sec <= 1'b0;
         s_reg.wd_count <= `WDG_COUNT_OFF;
         s_reg.wd_status <= 1'b0;
         s_reg.wd_load <= 1'b0;
         s_reg.rdata <= `WDG_RST_BYTE;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==================================================================
   // outputs
   assign bus_rdata = s_reg.rdata;
   assign wd_timeout = s_reg.wd_status;
endmodule

// File: tb/wdg_top_bench.sv
// self-checking bench of the watchdog/gpio block
`timescale 1ns/1ps
module wdg_top_bench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] bus_addr = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_wdata = 8'h00;
   logic [7:0] bus_rdata;
   logic [7:0] pin_in = 8'hA5;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic wd_timeout;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [7:0] d;
   logic [7:0] cfg_ofs [8] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2A, 8'h2B};
   always #2 clk = ~clk;
   // short second and minute so countdowns fit the run
   wdg_top #(.CYC_PER_SEC(10), .SECS_PER_MIN(3)) dut (.clk(clk), .reset(reset),
      .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .wd_timeout(wd_timeout));
   // ==========
   // bus and compare helpers
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(posedge clk);
      d = bus_rdata;
   endtask
   // lo..hi is the accepted arrival window, e the level expected at its end
   task automatic wait_to(input int lo, input int hi, input logic e);
      int n;
      n = 0;
      while (wd_timeout !== 1'b1 && n < hi) begin
         @(posedge clk);
         n++;
      end
      chk("timeout", {6'h00, wd_timeout, n >= lo && n <= hi}, {6'h00, e, 1'b1});
   endtask
   // ==========
   // scenarios
   task automatic t_reset();
      logic [7:0] ofs [6] = '{8'h47, 8'h4B, 8'h65, 8'h66, 8'h68, 8'h28};
      foreach (cfg_ofs[i]) begin
         rd(cfg_ofs[i]);
         chk("pin config", d, 8'h01);
      end
      foreach (ofs[i]) begin
         rd(ofs[i]);
         chk("reset byte", d, ofs[i] == 8'h4B ? pin_in : 8'h00);
      end
      $display("reset values done");
   endtask
   task automatic t_regs();
      logic [7:0] ofs [5] = '{8'h47, 8'h65, 8'h66, 8'h68, 8'h28};
      logic [7:0] exp [5] = '{8'hFF, 8'h80, 8'hFF, 8'h01, 8'h00};
      foreach (ofs[i]) begin
         wr(ofs[i], 8'hFF);
         rd(ofs[i]);
         chk("reg byte", d, exp[i]);
         wr(ofs[i], 8'h00);
      end
      wr(8'h2B, 8'h86);
      rd(8'h2B);
      chk("config byte", d, 8'h86);
      wr(8'h2B, 8'h01);
      $display("register access done");
   endtask
   task automatic t_pins();
      logic [7:0] m;
      for (int n = 0; n < 8; n++) begin
         m = 8'h01 << n;
         pin_in <= ~pin_in;
         wr(cfg_ofs[n], 8'h00);
         wr(8'h4B, m);
         @(posedge clk);
         chk("oe", pin_oe, m);
         chk("out", pin_out, m);
         rd(8'h4B);
         chk("levels", d, (pin_in & ~m) | m);
         wr(cfg_ofs[n], 8'h02);
         @(posedge clk);
         chk("inverted out", pin_out, 8'h00);
         wr(cfg_ofs[n], 8'h80);
         @(posedge clk);
         chk("od released", pin_oe | pin_out, 8'h00);
         wr(8'h4B, 8'h00);
         @(posedge clk);
         chk("od low", pin_oe | pin_out, m);
         wr(cfg_ofs[n], 8'h03);
         rd(8'h4B);
         chk("inverted in", d, pin_in ^ m);
         wr(cfg_ofs[n], 8'h01);
      end
      $display("pins done");
   endtask
   task automatic t_wdog();
      wr(8'h47, 8'h0C);
      wr(8'h65, 8'h80);
      wr(8'h66, 8'h02);
      wait_to(17, 27, 1'b1);
      rd(8'h68);
      chk("status", d, 8'h01);
      wr(8'h68, 8'h00);
      rd(8'h68);
      chk("status clear", d, 8'h00);
      wr(8'h66, 8'h02);
      repeat (12) @(posedge clk);
      wr(8'h66, 8'h02);
      wait_to(17, 27, 1'b1);
      wr(8'h66, 8'h00);
      wr(8'h68, 8'h00);
      wait_to(60, 60, 1'b0);
      wr(8'h65, 8'h00);
      wr(8'h66, 8'h01);
      wait_to(27, 37, 1'b1);
      wr(8'h66, 8'h00);
      wr(8'h68, 8'h00);
      wr(8'h47, 8'h0D);
      wr(8'h66, 8'h01);
      wait_to(60, 60, 1'b0);
      $display("watchdog done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // run should need about 500 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         results();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_regs();
      t_pins();
      t_wdog();
      results();
   end
endmodule

// File: tb/wdg_top_chk.sv
// port checker of the watchdog/gpio block
`timescale 1ns/1ps
module wdg_top_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic [7:0] pin_in,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic wd_timeout
);
   // ==========
   // shadows of pin 0 config and data bit and the count
   logic [7:0] cfg_reg;
   logic dat_reg;
   logic [7:0] cnt_reg;
   logic [3:0] zero_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_reg <= 8'h01;
         dat_reg <= 1'b0;
         cnt_reg <= 8'h00;
         zero_reg <= 4'hF;
      end else begin
         zero_reg <= {zero_reg[2:0], cnt_reg == 8'h00};
         if (bus_wr && bus_addr == 8'h23) cfg_reg <= bus_wdata;
         if (bus_wr && bus_addr == 8'h4B) dat_reg <= bus_wdata[0];
         if (bus_wr && bus_addr == 8'h66) cnt_reg <= bus_wdata;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   reset_clear_a: assert property (
      $fell(reset) |-> {bus_rdata, pin_out, pin_oe, wd_timeout} == 25'h0)
      else $error("outputs not cleared by reset");
   unmapped_zero_a: assert property (
      bus_rd && bus_addr == 8'h28 |=> bus_rdata == 8'h00) else $error("unmapped read");
   count_back_a: assert property (
      bus_rd && !bus_wr && bus_addr == 8'h66 |=> bus_rdata == $past(cnt_reg))
      else $error("count read back wrong");
   units_rsvd_a: assert property (
      bus_rd && bus_addr == 8'h65 |=> bus_rdata[6:0] == 7'h00) else $error("units reserved");
   status_read_a: assert property (
      bus_rd && !bus_wr && bus_addr == 8'h68 |=> bus_rdata == {7'h00, $past(wd_timeout)})
      else $error("status read wrong");
   zero_quiet_a: assert property (
      &zero_reg && cnt_reg == 8'h00 && !(bus_wr && bus_addr == 8'h68) |=> !$rose(wd_timeout))
      else $error("timeout with zero count");
   pin_input_a: assert property (
      cfg_reg[0] && $past(cfg_reg[0]) |-> !pin_oe[0]) else $error("input pin driven");
   open_drain_a: assert property (
      cfg_reg[7] && $past(cfg_reg[7]) |-> !pin_out[0]) else $error("open drain drives high");
   push_pull_a: assert property (
      !cfg_reg[0] && !cfg_reg[7] && $stable(cfg_reg) && $stable(dat_reg)
      |-> pin_oe[0] && pin_out[0] == (dat_reg ^ cfg_reg[1])) else $error("push-pull level");
   level_read_a: assert property (
      bus_rd && bus_addr == 8'h4B && cfg_reg[0]
      |=> bus_rdata[0] == ($past(pin_in[0]) ^ $past(cfg_reg[1]))) else $error("input level");
endmodule
bind wdg_top wdg_top_chk chk (.clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wr(bus_wr),
   .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .wd_timeout(wd_timeout));
